// ===== inc/ssm_pkg.sv
/*
  Shared constants and types for the search and slew controller: register map, field
  layouts, reset values, modes and slew timing.
  Assumes a 250 MHz system clock and a 32-bit APB register bus.
*/
package ssm_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 4;
  localparam int UPDATE_PERIOD_NS = 1_000_000;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NUM_GATES = 3;
  localparam int POS_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_POS0 = 8'h0c;
  localparam logic [7:0] REG_POS1 = 8'h10;
  localparam logic [7:0] REG_POS2 = 8'h14;
  localparam logic [7:0] REG_INTERVAL = 8'h18;

  // Command register bit positions (write one to act, reads as zero)
  localparam int CMD_LEFT = 0;
  localparam int CMD_RIGHT = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_FLIP = 3;

  // Status register bit positions
  localparam int ST_SLEWING = 0;
  localparam int ST_LEFT_LAMP = 1;
  localparam int ST_RIGHT_LAMP = 2;
  localparam int ST_OVERLAP = 3;
  localparam int ST_SIGNAL_LOSS = 4;
  localparam int ST_MASTER_READY = 5;
  localparam int ST_LOCK_LOSS = 8;
  localparam int ST_BLANK = 12;
  localparam int ST_CYCLE_COARSE = 16;
  localparam int ST_LOCK_IN = 20;

  typedef enum logic [2:0] {
    MODE_TRACK,
    MODE_MASTER,
    MODE_SEC1,
    MODE_SEC2,
    MODE_MULTI
  } ssm_mode_e;

  typedef struct packed {
    logic [2:0] envServoEn;
    logic [2:0] fineRate;
    logic [2:0] baseRate;
    logic [2:0] slewRate;
    ssm_mode_e mode;
  } ssm_ctrl_s;

  localparam int CTRL_W = 15;
  localparam logic [2:0] SLEW_MIN = 3'h1;
  localparam logic [2:0] SLEW_MAX = 3'h5;
  localparam logic [2:0] BASE_MAX = 3'h5;
  localparam ssm_ctrl_s CTRL_RESET = '{envServoEn: 3'h7, fineRate: 3'h0, baseRate: 3'h0,
                                       slewRate: SLEW_MIN, mode: MODE_TRACK};

  ////////////////////////////////////////////////////////////////////////////////
  // Slew speed per setting in microseconds per minute; 1 and 5 are the end points
  localparam int SLEW_US_PER_MIN [5] = '{1000, 2500, 5000, 7500, 10000};
  localparam longint NS_PER_MIN = 64'd60_000_000_000;

  // Base repetition intervals and fine step, in microseconds
  localparam int BASE_US [6] = '{100000, 80000, 60000, 50000, 40000, 30000};
  localparam int FINE_STEP_US = 100;
  localparam int NS_PER_US = 1000;

  // Gates nearer than this count as running into one another
  localparam logic [POS_W-1:0] GATE_WIDTH_NS = 32'h0000_2710;

  // Offset applied per update period, in ns, rounded down but at least one
  function automatic logic [POS_W-1:0] slew_step(input logic [2:0] rate, input longint periodNs);
    longint s;
    s = longint'(SLEW_US_PER_MIN[int'(rate) - 1]) * NS_PER_US * periodNs / NS_PER_MIN;
    if (s < 1) begin
      s = 1;
    end
    return s[POS_W-1:0];
  endfunction : slew_step

endpackage : ssm_pkg

// ===== hdl/ssm_sync.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes the inputs come from panel pins or the receiver outside the clock domain.
*/
`timescale 1ns/1ps
module ssm_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] async,
  output logic [W-1:0] sync
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
    end else if (ce) begin
      meta <= async;
      sync <= meta;
    end
  end

endmodule : ssm_sync

// ===== hdl/ssm_gate.sv
/*
  Position of one local timing gate within the repetition interval, in ns.
  Assumes the caller decides when it moves, in which direction and when it flips.
*/
`timescale 1ns/1ps
module ssm_gate
  import ssm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic stepEn,
  input wire logic dirLeft,
  input wire logic [POS_W-1:0] step,
  input wire logic [POS_W-1:0] interval,
  input wire logic flip,
  output logic [POS_W-1:0] pos,
  output logic limitHit
);

  logic [POS_W:0] sum;
  logic [POS_W:0] flipped;

  assign sum = {1'b0, pos} + {1'b0, step};
  assign flipped = {1'b0, pos} + {2'b00, interval[POS_W-1:1]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos <= '0;
      limitHit <= 1'b0;
    end else if (ce) begin
      limitHit <= 1'b0;
      if (flip) begin
        // Same place as slewing half an interval, wrapped
        pos <= (flipped >= {1'b0, interval}) ? POS_W'(flipped - {1'b0, interval})
                                             : flipped[POS_W-1:0];
      end else if (pos >= interval) begin
        pos <= interval - 1'b1;
      end else if (stepEn && dirLeft) begin
        if (pos < step) begin
          pos <= '0;
          limitHit <= 1'b1;
        end else begin
          pos <= pos - step;
        end
      end else if (stepEn) begin
        if (sum >= {1'b0, interval}) begin
          pos <= interval - 1'b1;
          limitHit <= 1'b1;
        end else begin
          pos <= sum[POS_W-1:0];
        end
      end
    end
  end

endmodule : ssm_gate

// ===== hdl/ssm_search_slew.sv
/*
  Search and slew controller: mode selection, slew rate, start/stop/direction,
  automatic reversal, code-group flip, overlap handling and lock-on lamps, with an
  APB slave for the operator controls.
  Assumes panel buttons and lock/coincidence flags arrive asynchronously, active high.
*/
// Notes on behaviour
// [RULE_01] Five-way mode: tracking, master, first secondary, second secondary, multi-gate.
// [RULE_02] Tracking mode: lamps watch lock on all three gates.
// [RULE_03] Operator returns selector to tracking once lock-on completes.
// [RULE_04] Acquisition always begins with master search.
// [RULE_05] Master search moves the master gate; lamps watch master only.
// [RULE_06] Secondary search: lamps watch only the selected secondary gate.
// [RULE_07] Operator seeks first secondary, then second secondary.
// [RULE_08] Multi-gate: all gates act as master; coincidence in any makes master ready.
// [RULE_09] Slew settings 1 to 5; 5 fastest, about 10000 us per minute.
// [RULE_10] Setting 1 slowest, about 1000 us per minute.
// [RULE_11] Press and release of a direction button starts continuous slewing.
// [RULE_12] At range limit slew reverses and the opposite lamp lights.
// [RULE_13] Slewing persists until lock-on or stop; the code also ends it on a mode change.
// [RULE_14] Direction lamp goes dark when slewing stops.
// [RULE_15] Stop ends any slewing still running.
// [RULE_16] Sky-wave: operator picks gate, slowest speed, slews left.
// [RULE_17] Flip button equals slewing half a repetition interval.
// [RULE_18] Interval set by six-way base and eight-way fine selectors.
// [RULE_19] Envelope servo off while tracking: cycle servo drives coarse and fine digits.
// [RULE_20] Gate overlap lights lamp, reverses, blanks a gate until clear; the code skips this in multi-gate mode.
// [RULE_21] Tracking: signal loss lamp lights when any gate loses lock.
// [RULE_22] Slew adds or removes a fixed offset per update period.
`timescale 1ns/1ps
module ssm_search_slew
  import ssm_pkg::*;
#(
  parameter int UPDATE_CYC = UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic leftButton,
  input wire logic rightButton,
  input wire logic stopButton,
  input wire logic flipButton,
  input wire logic [NUM_GATES-1:0] lockDetect,
  input wire logic [NUM_GATES-1:0] gateCoincidence,
  output logic [NUM_GATES-1:0][POS_W-1:0] gatePosition,
  output logic [NUM_GATES-1:0] gateBlank,
  output logic leftLamp,
  output logic rightLamp,
  output logic overlapLamp,
  output logic signalLossLamp,
  output logic [NUM_GATES-1:0] lockLossLamp,
  output logic masterReady,
  output logic [NUM_GATES-1:0] cycleDrivesCoarse,
  output logic [POS_W-1:0] repInterval
);

  typedef enum logic {SS_IDLE, SS_SLEW} ssm_state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Which gates a mode moves, and which lock monitors feed the lamps
  function automatic logic [NUM_GATES-1:0] active_gates(input ssm_mode_e m);
    case (m)
      MODE_MASTER: return 3'b001;
      MODE_SEC1: return 3'b010;
      MODE_SEC2: return 3'b100;
      MODE_MULTI: return 3'b111;
      default: return 3'b000;
    endcase
  endfunction : active_gates

  function automatic logic [NUM_GATES-1:0] monitored_gates(input ssm_mode_e m);
    case (m)
      MODE_TRACK: return 3'b111;
      MODE_MULTI: return 3'b001;
      default: return active_gates(m);
    endcase
  endfunction : monitored_gates

  function automatic logic too_close(input logic [POS_W-1:0] a, input logic [POS_W-1:0] b);
    return ((a > b) ? (a - b) : (b - a)) < GATE_WIDTH_NS;
  endfunction : too_close

  ssm_ctrl_s ctrl;
  ssm_state_e state;
  logic dirLeft;
  logic [3:0] btnSync;
  logic [3:0] btnPrev;
  logic [3:0] btnRelease;
  logic [NUM_GATES-1:0] lockSync;
  logic [NUM_GATES-1:0] coincSync;
  logic [NUM_GATES-1:0] activeMask;
  logic [NUM_GATES-1:0] limitHit;
  logic [31:0] tickCount;
  logic tick;
  logic [POS_W-1:0] step;
  logic overlapNow;
  logic [NUM_GATES-1:0] overlapPair;
  logic wrSetup;
  logic cmdLeft;
  logic cmdRight;
  logic cmdStop;
  logic cmdFlip;
  logic startLeft;
  logic startRight;
  logic stopReq;
  logic flipReq;
  logic lockedOn;
  ssm_mode_e prevMode;
  logic [31:0] statusWord;
  logic [31:0] next_rdata;
  logic mapped;
  logic [CTRL_W-1:0] ctrlBits;

  ////////////////////////////////////////////////////////////////////////////////
  ssm_sync #(.W(4)) u_btn_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async({flipButton, stopButton, rightButton, leftButton}),
    .sync(btnSync)
  );

  ssm_sync #(.W(2 * NUM_GATES)) u_rx_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .async({gateCoincidence, lockDetect}),
    .sync({coincSync, lockSync})
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      btnPrev <= '0;
    end else if (ce) begin
      btnPrev <= btnSync;
    end
  end

  // Buttons act on release, so a held button does not repeat
  assign btnRelease = btnPrev & ~btnSync; // [RULE_11]

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states; unmapped offsets answer with pslverr
  assign pready = 1'b1;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS) ||
                  (paddr == REG_POS0) || (paddr == REG_POS1) || (paddr == REG_POS2) ||
                  (paddr == REG_INTERVAL);
  assign pslverr = psel && penable && !mapped;
  assign wrSetup = psel && penable && pwrite && mapped;
  assign cmdLeft = wrSetup && (paddr == REG_CMD) && pstrb[0] && pwdata[CMD_LEFT];
  assign cmdRight = wrSetup && (paddr == REG_CMD) && pstrb[0] && pwdata[CMD_RIGHT];
  assign cmdStop = wrSetup && (paddr == REG_CMD) && pstrb[0] && pwdata[CMD_STOP];
  assign cmdFlip = wrSetup && (paddr == REG_CMD) && pstrb[0] && pwdata[CMD_FLIP];

  always_comb begin
    for (int b = 0; b < CTRL_W; b++) begin
      ctrlBits[b] = pstrb[b / 8] ? pwdata[b] : ctrl[b];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (ce && wrSetup && (paddr == REG_CTRL)) begin
      // Out-of-range selector codes are refused and the field keeps its value
      if (ctrlBits[2:0] <= 3'(MODE_MULTI)) begin
        ctrl.mode <= ssm_mode_e'(ctrlBits[2:0]); // [RULE_01]
      end
      if (ctrlBits[5:3] >= SLEW_MIN && ctrlBits[5:3] <= SLEW_MAX) begin
        ctrl.slewRate <= ctrlBits[5:3]; // [RULE_09] [RULE_10]
      end
      if (ctrlBits[8:6] <= BASE_MAX) begin
        ctrl.baseRate <= ctrlBits[8:6]; // [RULE_18]
      end
      ctrl.fineRate <= ctrlBits[11:9];
      ctrl.envServoEn <= ctrlBits[14:12];
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[ST_SLEWING] = (state == SS_SLEW);
    statusWord[ST_LEFT_LAMP] = leftLamp;
    statusWord[ST_RIGHT_LAMP] = rightLamp;
    statusWord[ST_OVERLAP] = overlapLamp;
    statusWord[ST_SIGNAL_LOSS] = signalLossLamp;
    statusWord[ST_MASTER_READY] = masterReady;
    statusWord[ST_LOCK_LOSS +: NUM_GATES] = lockLossLamp;
    statusWord[ST_BLANK +: NUM_GATES] = gateBlank;
    statusWord[ST_CYCLE_COARSE +: NUM_GATES] = cycleDrivesCoarse;
    statusWord[ST_LOCK_IN +: NUM_GATES] = lockSync;
    case (paddr)
      REG_CTRL: next_rdata = {17'h0_0000, ctrl};
      REG_STATUS: next_rdata = statusWord;
      REG_POS0: next_rdata = gatePosition[0];
      REG_POS1: next_rdata = gatePosition[1];
      REG_POS2: next_rdata = gatePosition[2];
      REG_INTERVAL: next_rdata = repInterval;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle and stands through the access phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (ce && psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Repetition interval and slew step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      repInterval <= POS_W'(BASE_US[0] * NS_PER_US);
      step <= slew_step(SLEW_MIN, longint'(UPDATE_CYC) * CLK_PERIOD_NS);
    end else if (ce) begin
      repInterval <= POS_W'((BASE_US[int'(ctrl.baseRate)] -
                             FINE_STEP_US * int'(ctrl.fineRate)) * NS_PER_US); // [RULE_18]
      step <= slew_step(ctrl.slewRate, longint'(UPDATE_CYC) * CLK_PERIOD_NS); // [RULE_09] [RULE_10]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCount <= '0;
    end else if (ce) begin
      tickCount <= tick ? '0 : tickCount + 1'b1;
    end
  end
  assign tick = (tickCount == 32'(UPDATE_CYC - 1)); // [RULE_22]

  ////////////////////////////////////////////////////////////////////////////////
  // Slew sequencing
  assign activeMask = active_gates(ctrl.mode);
  assign startLeft = (btnRelease[0] || cmdLeft) && (activeMask != '0);
  assign startRight = (btnRelease[1] || cmdRight) && (activeMask != '0);
  assign stopReq = btnRelease[2] || cmdStop;
  assign flipReq = btnRelease[3] || cmdFlip;
  assign lockedOn = |(lockSync & activeMask);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SS_IDLE;
      dirLeft <= 1'b0;
      prevMode <= MODE_TRACK;
    end else if (ce) begin
      prevMode <= ctrl.mode;
      case (state)
        SS_IDLE: begin
          if ((startLeft || startRight) && !stopReq) begin // [RULE_15]
            state <= SS_SLEW; // [RULE_11]
            dirLeft <= startLeft;
          end
        end
        SS_SLEW: begin
          // Mode change also stops, so a gate never keeps moving unseen
          if (stopReq || lockedOn || ctrl.mode != prevMode) begin
            state <= SS_IDLE; // [RULE_13] [RULE_15]
          end else if (startLeft || startRight) begin
            dirLeft <= startLeft;
          end else if ((|(limitHit & activeMask)) || (overlapNow && !overlapLamp)) begin
            dirLeft <= !dirLeft; // [RULE_12] [RULE_20]
          end
        end
        default: state <= SS_IDLE;
      endcase
    end
  end

  assign leftLamp = (state == SS_SLEW) && dirLeft; // [RULE_12] [RULE_14]
  assign rightLamp = (state == SS_SLEW) && !dirLeft; // [RULE_12] [RULE_14]

  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g++) begin : gen_gate
      ssm_gate u_gate (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .stepEn(tick && (state == SS_SLEW) && activeMask[g]), // [RULE_22] [RULE_05] [RULE_08]
        .dirLeft(dirLeft),
        .step(step),
        .interval(repInterval),
        .flip(flipReq && activeMask[g]), // [RULE_17]
        .pos(gatePosition[g]),
        .limitHit(limitHit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Overlap between gates; in multi-gate mode they all chase the master, so skipped
  assign overlapPair[0] = too_close(gatePosition[0], gatePosition[1]);
  assign overlapPair[1] = too_close(gatePosition[1], gatePosition[2]);
  assign overlapPair[2] = too_close(gatePosition[0], gatePosition[2]);
  assign overlapNow = (ctrl.mode != MODE_MULTI) && (|overlapPair);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overlapLamp <= 1'b0;
      gateBlank <= '0;
    end else if (ce) begin
      overlapLamp <= overlapNow; // [RULE_20]
      if (!overlapNow) begin
        gateBlank <= '0; // [RULE_20]
      end else if (gateBlank == '0) begin
        // Blank the moving gate when it is gate 0 or 1 and gates 0 and 1 overlap; otherwise the later gate of the overlapping pair
        gateBlank <= ((activeMask & 3'b011) != '0 && overlapPair[0]) ? (activeMask & 3'b011)
                   : (overlapPair[0] ? 3'b010 : 3'b100); // [RULE_20]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Lamps and servo routing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockLossLamp <= '0;
      signalLossLamp <= 1'b0;
      masterReady <= 1'b0;
      cycleDrivesCoarse <= '0;
    end else if (ce) begin
      lockLossLamp <= monitored_gates(ctrl.mode) & ~lockSync; // [RULE_02] [RULE_05] [RULE_06]
      signalLossLamp <= (ctrl.mode == MODE_TRACK) && !(&lockSync); // [RULE_21]
      masterReady <= (ctrl.mode == MODE_MULTI) ? (|coincSync)
                   : ((ctrl.mode == MODE_MASTER) && coincSync[0]); // [RULE_08]
      cycleDrivesCoarse <= (ctrl.mode == MODE_TRACK) ? ~ctrl.envServoEn : 3'b000; // [RULE_19]
    end
  end

endmodule : ssm_search_slew

// ===== test/ssm_rx_model.sv
/* Far side of the controller: received pulse timing and lock-on source.
   Assumes the bench places the received pulse and decides when each gate locks. */
`timescale 1ns/1ps
module ssm_rx_model
  import ssm_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_GATES-1:0][POS_W-1:0] gatePosition,
  input wire logic pulseOn,
  input wire logic [POS_W-1:0] pulsePos,
  input wire logic slow,
  input wire logic [NUM_GATES-1:0] lockReq,
  output logic [NUM_GATES-1:0] gateCoincidence,
  output logic [NUM_GATES-1:0] lockDetect
);
  logic [7:0][NUM_GATES-1:0] lockPipe;

  ////////////////////////////////////////////////////////////////////////////////
  // A slow receiver needs eight clock cycles before it reports lock
  always_ff @(posedge clk) begin
    lockPipe <= {lockPipe[6:0], lockReq};
  end
  assign lockDetect = slow ? lockPipe[7] : lockReq;

  always_comb begin
    for (int i = 0; i < NUM_GATES; i++) begin
      gateCoincidence[i] = pulseOn && pulsePos >= gatePosition[i] &&
                           pulsePos - gatePosition[i] < GATE_WIDTH_NS;
    end
  end
endmodule : ssm_rx_model

// ===== test/ssm_search_slew_sva.sv
/* Port checks for the search and slew controller.
   Assumes ce is held high and that the bench binds this to the top module. */
`timescale 1ns/1ps
module ssm_search_slew_sva
  import ssm_pkg::*;
#(
  parameter int UPDATE_CYC = UPDATE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic stopButton,
  input wire logic [NUM_GATES-1:0] lockDetect,
  input wire logic [NUM_GATES-1:0] gateCoincidence,
  input wire logic [NUM_GATES-1:0][POS_W-1:0] gatePosition,
  input wire logic leftLamp,
  input wire logic rightLamp,
  input wire logic signalLossLamp,
  input wire logic [NUM_GATES-1:0] lockLossLamp,
  input wire logic masterReady,
  input wire logic [POS_W-1:0] repInterval
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  lamps_exclusive_a: assert property (
    !(leftLamp && rightLamp)) else $error("both slew lamps lit");
  stop_cmd_a: assert property (
    psel && penable && pwrite && paddr == REG_CMD && pwdata[CMD_STOP]
    |=> !leftLamp && !rightLamp) else $error("lamp lit after stop command");
  stop_button_a: assert property (
    $fell(stopButton) |-> ##[1:8] (!leftLamp && !rightLamp))
    else $error("lamp lit after stop button");
  track_lock_a: assert property (
    (lockDetect == 3'h7) [*5] |-> lockLossLamp == 3'h0)
    else $error("lock loss lamp with all gates locked");
  loss_lamp_a: assert property (
    signalLossLamp |-> lockLossLamp != 3'h0 || $past(lockLossLamp) != 3'h0)
    else $error("signal loss lamp without lost gate");
  ready_clear_a: assert property (
    (gateCoincidence == 3'h0) [*5] |-> !masterReady)
    else $error("master ready without coincidence");
  interval_range_a: assert property (
    repInterval >= 32'h01bf1520 && repInterval <= 32'h05f5e100)
    else $error("interval outside selector range");
  pos_range_a: assert property (
    $stable(repInterval) [*3] |-> gatePosition[0] < repInterval &&
    gatePosition[1] < repInterval && gatePosition[2] < repInterval)
    else $error("gate outside interval");
endmodule : ssm_search_slew_sva

// ===== test/tb_search_slew_mode_control.sv
/* Self-checking bench for the search and slew controller.
   Assumes the package, the far-side model and the checker are compiled first. */
`timescale 1ns/1ps
module tb_search_slew_mode_control
  import ssm_pkg::*;
;
  localparam int UC = 3000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pulseOn = 1'b0, slowLock = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rdData, p1;
  logic [3:0] pstrb = 4'hf, btn = 4'h0;
  logic [2:0] lockReq = 3'h0, lockDetect, gateCoincidence, gateBlank, lockLossLamp, cdc;
  logic [NUM_GATES-1:0][POS_W-1:0] gatePosition;
  logic pready, pslverr, errFlag, leftLamp, rightLamp, overlapLamp, signalLossLamp, masterReady;
  logic [POS_W-1:0] repInterval, pulsePos = 32'h0;
  int error_cnt = 0, samples_checked = 0, cyc = 0, t0, s, f, e;
  int md[5] = '{0, 3, 1, 2, 0}, lk[5] = '{5, 3, 6, 5, 7};
  int ex[5] = '{10, 4, 1, 2, 0};
  integer seed = 32'hd93c;

  ssm_search_slew #(.UPDATE_CYC(UC)) dut_u (
    .clk, .rst_n, .ce(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .leftButton(btn[0]), .rightButton(btn[1]), .stopButton(btn[2]),
    .flipButton(btn[3]), .lockDetect, .gateCoincidence, .gatePosition, .gateBlank,
    .leftLamp, .rightLamp, .overlapLamp, .signalLossLamp, .lockLossLamp, .masterReady,
    .cycleDrivesCoarse(cdc), .repInterval);
  ssm_rx_model rx_u (.clk, .gatePosition, .pulseOn, .pulsePos, .slow(slowLock), .lockReq,
    .gateCoincidence, .lockDetect);

  ////////////////////////////////////////////////////////////////////////////////
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("wrong value at %0t: run timed out", $time);
      tally_and_finish();
    end
  end

  function automatic logic [31:0] ctrl(input int m, sl, b, fi, en);
    return 32'(en * 4096 + fi * 512 + b * 64 + sl * 8 + m);
  endfunction : ctrl

  // Travel per update period: us per minute scaled to the tick length in ns
  function automatic longint stepOf(input int r);
    longint st;
    st = longint'(SLEW_US_PER_MIN[r - 1]) * NS_PER_US * UC * CLK_PERIOD_NS / NS_PER_MIN;
    return (st < 1) ? 1 : st;
  endfunction : stepOf

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One idle edge first, so back-to-back calls never assign psel twice at one edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdData = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic press(input int k);
    @(posedge clk);
    btn[k] <= 1'b1;
    repeat (2 + $unsigned($random(seed)) % 8) @(posedge clk);
    btn[k] <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask : press

  // Reads a gate twice, exactly two update periods apart
  task automatic measure(input logic [7:0] a, input longint d);
    logic [31:0] first;
    @(posedge clk);
    t0 = cyc;
    apb(1'b0, a, 32'h0);
    first = rdData;
    while (cyc != t0 + 2 * UC) @(posedge clk);
    apb(1'b0, a, 32'h0);
    chk(rdData - first, 32'(d), "gate travel");
  endtask : measure

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rdData, 32'h7008, "ctrl reset");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, errFlag}, 32'h1, "unmapped");
    for (int m = 0; m < 6; m++) begin
      s = 1 + $unsigned($random(seed)) % 5;
      apb(1'b1, REG_CTRL, ctrl(m, s, 0, 0, 7));
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rdData, ctrl(m < 5 ? m : 4, s, 0, 0, 7), "mode");
    end
    for (int b = 0; b < 6; b++) begin
      f = $unsigned($random(seed)) % 8;
      e = $unsigned($random(seed)) % 8;
      apb(1'b1, REG_CTRL, ctrl(0, 1, b, f, e));
      apb(1'b0, REG_INTERVAL, 32'h0);
      chk(rdData, 32'((BASE_US[b] - FINE_STEP_US * f) * NS_PER_US), "interval");
      chk({29'h0, cdc}, 32'(~e & 7), "cycle servo");
    end
    apb(1'b1, REG_CMD, 32'h1);
    @(negedge clk);
    chk({leftLamp, rightLamp}, 32'h0, "track start");
    chk({overlapLamp, gateBlank}, 32'ha, "overlap at rest");
    $display("test registers finished");
    apb(1'b1, REG_CTRL, ctrl(1, 5, 0, 0, 7));
    apb(1'b1, REG_CMD, 32'h1);
    repeat (UC + 4) @(posedge clk);
    @(negedge clk);
    chk({leftLamp, rightLamp}, 32'h1, "reversal");
    measure(REG_POS0, 2 * stepOf(5));
    apb(1'b1, REG_CMD, 32'h4);
    @(negedge clk);
    chk({leftLamp, rightLamp}, 32'h0, "stop");
    measure(REG_POS0, 0);
    apb(1'b1, REG_CTRL, ctrl(2, 1, 0, 0, 7));
    apb(1'b0, REG_POS0, 32'h0);
    p1 = rdData;
    apb(1'b1, REG_CMD, 32'h2);
    measure(REG_POS1, 2 * stepOf(1));
    apb(1'b0, REG_POS0, 32'h0);
    chk(rdData, p1, "idle gate");
    press(2);
    chk({leftLamp, rightLamp}, 32'h0, "stop button");
    $display("test slew finished");
    apb(1'b1, REG_CTRL, ctrl(1, 1, 0, 0, 7));
    press(0);
    chk({leftLamp, rightLamp}, 32'h2, "left button");
    @(posedge clk) slowLock <= 1'b1;
    lockReq <= 3'h1;
    repeat (30) @(posedge clk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rdData[ST_SLEWING]}, 32'h0, "lock stops slew");
    lockReq <= 3'h0;
    slowLock <= 1'b0;
    apb(1'b1, REG_CTRL, ctrl(2, 1, 0, 0, 7));
    apb(1'b0, REG_POS1, 32'h0);
    p1 = rdData;
    press(3);
    apb(1'b0, REG_POS1, 32'h0);
    chk(rdData, 32'((longint'(p1) + 50000000) % 100000000), "flip");
    p1 = rdData;
    apb(1'b1, REG_CTRL, ctrl(0, 1, 0, 0, 7));
    apb(1'b1, REG_CMD, 32'h8);
    apb(1'b0, REG_POS1, 32'h0);
    chk(rdData, p1, "track flip");
    $display("test flip finished");
    pulsePos <= gatePosition[1] + 32'h5;
    pulseOn <= 1'b1;
    for (int m = 4; m > 0; m -= 3) begin
      apb(1'b1, REG_CTRL, ctrl(m, 1, 0, 0, 7));
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({31'h0, masterReady}, 32'(m == 4), "master ready");
      chk({overlapLamp, gateBlank}, (m == 4) ? 32'h0 : 32'hc, "overlap");
    end
    @(posedge clk) pulseOn <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, REG_CTRL, ctrl(md[i], 1, 0, 0, 7));
      lockReq <= 3'(lk[i]);
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk({signalLossLamp, lockLossLamp}, 32'(ex[i]), "lamps");
    end
    $display("test lamps finished");
    tally_and_finish();
  end
endmodule : tb_search_slew_mode_control

bind ssm_search_slew ssm_search_slew_sva #(.UPDATE_CYC(UPDATE_CYC)) chk_u (.clk, .rst_n,
  .paddr, .psel, .penable, .pwrite, .pwdata, .stopButton, .lockDetect, .gateCoincidence,
  .gatePosition, .leftLamp, .rightLamp, .signalLossLamp, .lockLossLamp, .masterReady,
  .repInterval);
